// *** design/ccr_loader.v ***
/*
 * Calibration constant checksum and restore sequencer.
 * Holds the working copy in flip-flops; reads the protected and default
 * copies through simple one-cycle read ports, writes the protected copy
 * through a write port with a done/fail answer. All inputs but nrst_i are synchronous.
 */
//Contract
//RQ1 - Keep working, protected and default tables
//RQ2 - Normal reads come from working copy only
//RQ3 - Preset sums 1..98, complements, compares slot 99
//RQ4 - Match leaves working copy, no fault
//RQ5 - Mismatch copies protected, then rechecks
//RQ6 - Second pass reports backup restored message
//RQ7 - Second fail loads defaults, lamp, message
//RQ8 - Defaulting never writes the protected copy
//RQ9 - Diagnostics request shows diagnostics, lamp flashes
//RQ10 - Any constant write recomputes stored checksum
//RQ11 - Update during fault clears fault at preset
//RQ12 - Transfer recomputes checksum, then writes protected copy
//RQ13 - Failed protected write reports storage failure
//RQ14 - Sum is 16-bit modulo, carries dropped
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_loader #(
	parameter FLASH_CYC = `CCR_FLASH_CYC
) (
	input wire clock_i,
	input wire nrst_i,
	input wire full_reinit_key_i, // Pulse: instrument preset
	input wire diag_req_i, // Pulse: show fault diagnostics
	input wire store_req_i, // Pulse: working to protected transfer
	input wire recall_req_i, // Pulse: protected to working transfer
	input wire [6:0] rd_addr_i, // Normal read slot
	output reg [15:0] rd_data_o, // Normal read data, working copy
	input wire wr_en_i, // Pulse: user writes one constant
	input wire [6:0] wr_addr_i,
	input wire [15:0] wr_data_i,
	output reg [6:0] prot_addr_o, // Protected store address
	input wire [15:0] prot_data_i, // Protected read data, next cycle
	output reg prot_wr_o, // Protected write strobe
	output reg [15:0] prot_wdata_o,
	input wire prot_done_i, // Protected write accepted
	input wire prot_fail_i, // Protected write failed
	output reg [6:0] dflt_addr_o, // Default store address
	input wire [15:0] dflt_data_i, // Default read data, next cycle
	output reg busy_o, // Sequencer active
	output reg fault_lamp_o, // Front-panel fault lamp
	output reg cal_lamp_o, // Calibration lamp, flashes in diagnostics
	output reg diag_show_o, // Entry display shows diagnostics
	output reg backup_restored_message_o, // Level until next preset
	output reg defaults_loaded_message_o, // Level until next preset
	output reg store_fail_message_o // Level until next store request
);
	// State codes
	localparam S_IDLE = 4'h0;
	localparam S_SUM = 4'h1;
	localparam S_CMP = 4'h2;
	localparam S_PCPY = 4'h3;
	localparam S_DCPY = 4'h4;
	localparam S_WSUM = 4'h5;
	localparam S_PWR = 4'h6;
	localparam S_PWAIT = 4'h7;
	localparam S_RCPY = 4'h8;
	localparam CW = 24;
	// Working table, slot 0 unused (see RQ1)
	reg [15:0] table_reg [0:127];
	reg [3:0] state_reg;
	reg [6:0] idx_reg; // Slot being walked
	reg [15:0] acc_reg; // Running sum
	reg second_reg; // Checking after a protected copy
	reg rd_pend_reg; // Store read issued last cycle
	reg edited_reg; // Constant changed while in fault
	reg xfer_reg; // Checksum walk ends in a protected write, not a plain edit
	reg [CW-1:0] flash_cnt_reg;
	reg flash_reg;
	// Default copy source: only when the second check failed (see RQ7)
	wire use_dflt = (state_reg == S_DCPY);
	wire [15:0] src_word = use_dflt ? dflt_data_i : prot_data_i;
	wire [15:0] sum_cmp = ~acc_reg; // Complemented sum (see RQ3)

	// Normal reads come from the working table only (see RQ2)
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			rd_data_o <= table_reg[rd_addr_i];
		end
	end

	// Flash divider, runs while diagnostics show; lamp toggles each half period
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flash_cnt_reg <= {CW{1'b0}};
			flash_reg <= 1'b0;
		end else if (!diag_show_o) begin
			flash_cnt_reg <= {CW{1'b0}};
			flash_reg <= 1'b0;
		end else if (flash_cnt_reg == FLASH_CYC[CW-1:0] - 24'h00_0001) begin
			flash_cnt_reg <= {CW{1'b0}};
			flash_reg <= ~flash_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 24'h00_0001;
		end
	end

	// Sequencer; user writes are taken only while idle to keep the table stable
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= S_IDLE;
			idx_reg <= 7'h00;
			acc_reg <= 16'h0000;
			second_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			edited_reg <= 1'b0;
			xfer_reg <= 1'b0;
			busy_o <= 1'b0;
			fault_lamp_o <= 1'b0;
			cal_lamp_o <= 1'b0;
			diag_show_o <= 1'b0;
			backup_restored_message_o <= 1'b0;
			defaults_loaded_message_o <= 1'b0;
			store_fail_message_o <= 1'b0;
			prot_addr_o <= 7'h00;
			prot_wr_o <= 1'b0;
			prot_wdata_o <= 16'h0000;
			dflt_addr_o <= 7'h00;
		end else begin
			prot_wr_o <= 1'b0;
			// Lamp: steady with fault, flashing under diagnostics (see RQ9)
			cal_lamp_o <= fault_lamp_o & (diag_show_o ? flash_reg : 1'b1);
			case (state_reg)
				S_IDLE: begin
					busy_o <= 1'b0;
					if (diag_req_i && fault_lamp_o) begin
						diag_show_o <= 1'b1; // see RQ9
					end
					if (full_reinit_key_i) begin
						// Preset starts a fresh check (see RQ3)
						state_reg <= S_SUM;
						idx_reg <= `CCR_FIRST_SLOT;
						acc_reg <= 16'h0000;
						second_reg <= 1'b0;
						busy_o <= 1'b1;
						diag_show_o <= 1'b0;
						backup_restored_message_o <= 1'b0;
						defaults_loaded_message_o <= 1'b0;
					end else if (store_req_i) begin
						// Transfer first refreshes checksum (see RQ12)
						state_reg <= S_WSUM;
						idx_reg <= `CCR_FIRST_SLOT;
						acc_reg <= 16'h0000;
						busy_o <= 1'b1;
						store_fail_message_o <= 1'b0;
						xfer_reg <= 1'b1; // see RQ12
					end else if (recall_req_i) begin
						state_reg <= S_RCPY;
						idx_reg <= `CCR_FIRST_SLOT;
						prot_addr_o <= `CCR_FIRST_SLOT;
						rd_pend_reg <= 1'b0;
						busy_o <= 1'b1;
					end else if (wr_en_i && wr_addr_i >= `CCR_FIRST_SLOT
						&& wr_addr_i <= `CCR_LAST_SLOT) begin
						// Store the word, then recompute checksum (see RQ10)
						xfer_reg <= 1'b0;
						state_reg <= S_WSUM;
						idx_reg <= `CCR_FIRST_SLOT;
						acc_reg <= 16'h0000;
						busy_o <= 1'b1;
						if (fault_lamp_o) begin
							edited_reg <= 1'b1; // see RQ11
						end
					end
				end
				S_SUM, S_WSUM: begin
					// 16-bit wrap, carries dropped (see RQ14)
					acc_reg <= acc_reg + table_reg[idx_reg];
					if (idx_reg == `CCR_LAST_SLOT) begin
						if (state_reg == S_SUM) begin
							state_reg <= S_CMP;
						end else if (xfer_reg) begin
							// Only a transfer may reach the protected copy (see RQ12)
							state_reg <= S_PWR;
						end else begin
							// An edit refreshes the working checksum only
							state_reg <= S_IDLE;
						end
						idx_reg <= `CCR_FIRST_SLOT;
					end else begin
						idx_reg <= idx_reg + 7'h01;
					end
				end
				S_CMP: begin
					if (sum_cmp == table_reg[`CCR_SUM_SLOT] || edited_reg) begin
						// Pass: table untouched (see RQ4); edit clears fault (see RQ11)
						state_reg <= S_IDLE;
						fault_lamp_o <= 1'b0;
						edited_reg <= 1'b0;
						backup_restored_message_o <= second_reg; // see RQ6
					end else if (!second_reg) begin
						state_reg <= S_PCPY; // see RQ5
						prot_addr_o <= `CCR_FIRST_SLOT;
						rd_pend_reg <= 1'b0;
					end else begin
						// Protected store is only read here (see RQ8)
						state_reg <= S_DCPY; // see RQ7
						dflt_addr_o <= `CCR_FIRST_SLOT;
						rd_pend_reg <= 1'b0;
					end
					idx_reg <= `CCR_FIRST_SLOT;
					acc_reg <= 16'h0000;
				end
				S_PCPY, S_DCPY, S_RCPY: begin
					// One-cycle read latency: address leads data by a cycle
					rd_pend_reg <= 1'b1;
					if (prot_addr_o != `CCR_SUM_SLOT || use_dflt) begin
						prot_addr_o <= prot_addr_o + 7'h01;
					end
					if (dflt_addr_o != `CCR_SUM_SLOT || !use_dflt) begin
						dflt_addr_o <= dflt_addr_o + 7'h01;
					end
					if (rd_pend_reg) begin
						idx_reg <= idx_reg + 7'h01;
						if (idx_reg == `CCR_SUM_SLOT) begin
							idx_reg <= `CCR_FIRST_SLOT;
							if (state_reg == S_PCPY) begin
								state_reg <= S_SUM; // Recheck (see RQ5)
								second_reg <= 1'b1;
							end else if (state_reg == S_DCPY) begin
								state_reg <= S_IDLE;
								fault_lamp_o <= 1'b1; // see RQ7
								defaults_loaded_message_o <= 1'b1;
							end else begin
								state_reg <= S_IDLE;
							end
						end
					end
				end
				S_PWR: begin
					// Walk all 99 slots out to the protected store (see RQ12)
					prot_addr_o <= idx_reg;
					prot_wdata_o <= (idx_reg == `CCR_SUM_SLOT) ? sum_cmp : table_reg[idx_reg];
					prot_wr_o <= 1'b1;
					state_reg <= S_PWAIT;
				end
				S_PWAIT: begin
					if (prot_fail_i) begin
						store_fail_message_o <= 1'b1; // see RQ13
						state_reg <= S_IDLE;
					end else if (prot_done_i) begin
						if (idx_reg == `CCR_SUM_SLOT) begin
							state_reg <= S_IDLE;
						end else begin
							idx_reg <= idx_reg + 7'h01;
							state_reg <= S_PWR;
						end
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// Working table writes: user edit, copy-in, checksum store (see RQ1)
	always @(posedge clock_i) begin
		if (state_reg == S_IDLE && !full_reinit_key_i && !store_req_i && !recall_req_i
			&& wr_en_i && wr_addr_i >= `CCR_FIRST_SLOT && wr_addr_i <= `CCR_LAST_SLOT) begin
			table_reg[wr_addr_i] <= wr_data_i;
		end else if ((state_reg == S_PCPY || state_reg == S_DCPY || state_reg == S_RCPY)
			&& rd_pend_reg) begin
			table_reg[idx_reg] <= src_word;
		end else if (state_reg == S_WSUM && idx_reg == `CCR_LAST_SLOT) begin
			table_reg[`CCR_SUM_SLOT] <= ~(acc_reg + table_reg[idx_reg]); // see RQ10
		end
	end
endmodule // ccr_loader

// *** design/ccr_consts.vh ***
/*
 * Constants for the calibration table check and restore sequencer.
 * Assumes a table of 99 sixteen-bit words, slot 99 being the checksum.
 */
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// First and last data slot summed into the checksum
`define CCR_FIRST_SLOT 7'h01
`define CCR_LAST_SLOT 7'h62
// Slot that holds the stored checksum
`define CCR_SUM_SLOT 7'h63
// Word width of a constant
`define CCR_WORD_W 16
// Half flash period of the calibration lamp, in milliseconds
`define CCR_FLASH_MS 250
// Clock rate in kHz, used to derive cycle counts
`define CCR_CLK_KHZ 40000
// Cycles per half flash period (250 ms at 40 MHz)
`define CCR_FLASH_CYC (`CCR_FLASH_MS * `CCR_CLK_KHZ)
`endif

// *** sim/ccr_loader_assertions.sv ***
/* Checker for the calibration check and restore sequencer.
   Sees only the loader's ports; bound to every loader instance below. */
`timescale 1ns/1ps
module ccr_loader_assertions #(
	parameter FLASH_CYC = 4
) (
	input wire clock_i,
	input wire nrst_i,
	input wire full_reinit_key_i,
	input wire store_req_i,
	input wire prot_wr_o,
	input wire prot_fail_i,
	input wire busy_o,
	input wire fault_lamp_o,
	input wire cal_lamp_o,
	input wire diag_show_o,
	input wire backup_restored_message_o,
	input wire defaults_loaded_message_o,
	input wire store_fail_message_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	reg in_preset_reg; // A preset run is in progress
	reg in_store_reg; // A transfer to the protected copy is in progress
	reg lamp_prev_reg; // Lamp level one cycle back
	reg [7:0] flash_cnt_reg; // Cycles the lamp has held still in diagnostics
	// Helper state: preset window and lamp hold time
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_preset_reg <= 1'b0;
			in_store_reg <= 1'b0;
			lamp_prev_reg <= 1'b0;
			flash_cnt_reg <= 8'h00;
		end else begin
			in_preset_reg <= (full_reinit_key_i && !busy_o) || (in_preset_reg && busy_o);
			// Preset outranks a store taken in the same cycle
			in_store_reg <= (store_req_i && !full_reinit_key_i && !busy_o) ||
				(in_store_reg && busy_o);
			lamp_prev_reg <= cal_lamp_o;
			flash_cnt_reg <= (diag_show_o && cal_lamp_o == lamp_prev_reg) ?
				flash_cnt_reg + 8'h01 : 8'h00;
		end
	end
	busy_take_a: assert property (full_reinit_key_i && !busy_o |=> busy_o)
		else $error("preset request not taken");
	seq_bound_a: assert property ($rose(busy_o) |-> ##[1:1000] !busy_o)
		else $error("sequence did not finish");
	prot_wr_busy_a: assert property (prot_wr_o |-> busy_o)
		else $error("protected write outside a transfer");
	preset_no_wr_a: assert property (in_preset_reg |-> !prot_wr_o)
		else $error("protected copy written during preset");
	store_only_wr_a: assert property (prot_wr_o |-> in_store_reg)
		else $error("protected write without a transfer request");
	default_lamp_a: assert property (!busy_o && fault_lamp_o |-> defaults_loaded_message_o)
		else $error("fault lamp without defaults message");
	restored_ok_a: assert property (!busy_o && backup_restored_message_o |->
		!fault_lamp_o && !defaults_loaded_message_o)
		else $error("restore reported with fault");
	diag_fault_a: assert property ($rose(diag_show_o) |-> fault_lamp_o)
		else $error("diagnostics shown without fault");
	flash_rate_a: assert property (flash_cnt_reg <= FLASH_CYC)
		else $error("calibration lamp not flashing");
	store_fail_a: assert property (prot_fail_i && busy_o |-> ##[1:4] store_fail_message_o)
		else $error("failed store not reported");
	cover property ($rose(backup_restored_message_o));
	cover property ($rose(defaults_loaded_message_o));
	cover property ($rose(store_fail_message_o));
endmodule // ccr_loader_assertions

bind ccr_loader ccr_loader_assertions #(.FLASH_CYC(FLASH_CYC)) ccr_loader_assertions_i (
	.clock_i(clock_i), .nrst_i(nrst_i), .full_reinit_key_i(full_reinit_key_i),
	.store_req_i(store_req_i),
	.prot_wr_o(prot_wr_o), .prot_fail_i(prot_fail_i), .busy_o(busy_o),
	.fault_lamp_o(fault_lamp_o), .cal_lamp_o(cal_lamp_o), .diag_show_o(diag_show_o),
	.backup_restored_message_o(backup_restored_message_o),
	.defaults_loaded_message_o(defaults_loaded_message_o),
	.store_fail_message_o(store_fail_message_o));

// *** sim/ccr_store_model.sv ***
/* Far side of the loader: protected store with registered reads and a
   write answer, and a read-only default store. Tables are preloaded by
   the bench through hierarchical access. */
`timescale 1ns/1ps
module ccr_store_model (
	input wire logic clock_i,
	input wire logic slow_i, // Answer writes after three cycles, not one
	input wire logic fail_en_i, // Refuse writes and answer with fail
	input wire logic [6:0] prot_addr_i,
	output logic [15:0] prot_data_o,
	input wire logic prot_wr_i,
	input wire logic [15:0] prot_wdata_i,
	output logic prot_done_o,
	output logic prot_fail_o,
	input wire logic [6:0] dflt_addr_i,
	output logic [15:0] dflt_data_o
);
	logic [15:0] prot_mem [0:127]; // Protected copy
	logic [15:0] dflt_mem [0:127]; // Averaged defaults, never written here
	logic [2:0] pend = 3'h0; // Write answers in flight
	logic ans;
	// Synchronous reads: data lands one cycle after the address
	always @(posedge clock_i) begin
		prot_data_o <= prot_mem[prot_addr_i];
		dflt_data_o <= dflt_mem[dflt_addr_i];
		pend <= {pend[1:0], prot_wr_i};
		// A refused write keeps the old word, as a worn cell would
		if (prot_wr_i && !fail_en_i) begin
			prot_mem[prot_addr_i] <= prot_wdata_i;
		end
	end
	assign ans = slow_i ? pend[2] : pend[0];
	assign prot_done_o = ans && !fail_en_i;
	assign prot_fail_o = ans && fail_en_i;
endmodule // ccr_store_model

// *** sim/tb_cal_constant_checksum_restore.sv ***
/* Bench for the calibration check and restore sequencer: random tables,
   preset pass, restore, default fallback, diagnostics, store and failure.
   Assumes the store model answers the loader's far side. */
`timescale 1ns/1ps
module tb_cal_constant_checksum_restore;
	localparam int FLASH = 4; // Short flash period keeps the run brief
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic key = 0, diag = 0, store = 0, recall = 0, wr_en = 0, slow = 0, fail_en = 0;
	logic [6:0] rd_addr = 0, wr_addr = 0, prot_addr, dflt_addr;
	logic [15:0] wr_data = 0, rd_data, prot_data, dflt_data, prot_wdata;
	logic prot_wr, prot_done, prot_fail, busy, fault, cal, dshow, rmsg, dmsg, fmsg, last;
	logic [15:0] work [0:127]; // Expected working copy
	logic [15:0] ptab [0:127]; // Expected protected copy
	logic [15:0] dtab [0:127]; // Default copy
	logic [31:0] seed = 32'h2622_1230;
	int n_mismatch = 0;
	int n_compared = 0;
	int i, k;
	always #12.5 clock_i = ~clock_i;
	ccr_loader #(.FLASH_CYC(FLASH)) ccr_loader_i (.clock_i(clock_i), .nrst_i(nrst_i),
		.full_reinit_key_i(key), .diag_req_i(diag), .store_req_i(store), .recall_req_i(recall),
		.rd_addr_i(rd_addr), .rd_data_o(rd_data), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
		.wr_data_i(wr_data), .prot_addr_o(prot_addr), .prot_data_i(prot_data),
		.prot_wr_o(prot_wr), .prot_wdata_o(prot_wdata), .prot_done_i(prot_done),
		.prot_fail_i(prot_fail), .dflt_addr_o(dflt_addr), .dflt_data_i(dflt_data),
		.busy_o(busy), .fault_lamp_o(fault), .cal_lamp_o(cal), .diag_show_o(dshow),
		.backup_restored_message_o(rmsg), .defaults_loaded_message_o(dmsg),
		.store_fail_message_o(fmsg));
	ccr_store_model ccr_store_model_i (.clock_i(clock_i), .slow_i(slow), .fail_en_i(fail_en),
		.prot_addr_i(prot_addr), .prot_data_o(prot_data), .prot_wr_i(prot_wr),
		.prot_wdata_i(prot_wdata), .prot_done_o(prot_done), .prot_fail_o(prot_fail),
		.dflt_addr_i(dflt_addr), .dflt_data_o(dflt_data));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Complemented sum of slots 1 to 98, carries dropped
	function automatic logic [15:0] csum(input logic [15:0] t [0:127]);
		logic [15:0] s;
		s = 16'h0000;
		for (int j = 1; j <= 98; j++) s += t[j];
		return ~s;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Wait for the sequencer to go idle, bounded
	task automatic settle();
		for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clock_i) #2;
		if (i == 2000) check(16'h0001, 16'h0000);
	endtask
	// One request pulse: 0 preset, 1 store, 2 recall, 3 diagnostics
	task automatic req(input int c);
		key <= (c == 0);
		store <= (c == 1);
		recall <= (c == 2);
		diag <= (c == 3);
		@(posedge clock_i) #2;
		{key, store, recall, diag} <= 4'h0;
		settle();
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clock_i) #2;
		wr_en <= 1'b0;
		work[a] = d;
		work[99] = csum(work);
		@(posedge clock_i) #2;
		settle();
	endtask
	task automatic chk_tab(input logic [15:0] t [0:127]);
		for (k = 1; k <= 99; k++) begin
			rd_addr <= k[6:0];
			@(posedge clock_i) #2;
			check(rd_data, t[k]);
		end
	endtask
	task automatic chk_prot(input logic [15:0] t [0:127]);
		for (k = 1; k <= 99; k++) check(ccr_store_model_i.prot_mem[k], t[k]);
	endtask
	task print_verdict;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under ten thousand cycles
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clock_i);
		#2 nrst_i = 1'b1;
		check({busy, fault, prot_wr, dshow}, 16'h0000);
		for (k = 0; k < 128; k++) begin
			ptab[k] = 16'(xs());
			dtab[k] = 16'(xs());
		end
		ptab[1] = 16'hffff; // Forces carries out of the sum
		ptab[98] = 16'hffff;
		ptab[99] = csum(ptab);
		dtab[99] = csum(dtab);
		for (k = 1; k <= 99; k++) ccr_store_model_i.prot_mem[k] = ptab[k];
		for (k = 1; k <= 99; k++) ccr_store_model_i.dflt_mem[k] = dtab[k];
		req(2);
		work = ptab;
		chk_tab(work);
		req(0);
		check({fault, rmsg, dmsg}, 16'h0000);
		// Diagnostics are refused while no fault stands
		req(3);
		check({dshow, cal}, 16'h0000);
		wr(7'h05, 16'(xs()));
		chk_tab(work);
		// An edit must leave the protected copy alone
		chk_prot(ptab);
		req(0);
		check({fault, rmsg, dmsg}, 16'h0000);
		slow = 1'b1;
		req(1);
		chk_prot(work);
		check(fmsg, 16'h0000);
		ptab = work;
		// Bad working copy, good protected copy
		ccr_store_model_i.prot_mem[5] ^= 16'h0001;
		req(2);
		ccr_store_model_i.prot_mem[5] ^= 16'h0001;
		req(0);
		check({fault, rmsg, dmsg}, 16'h0002);
		chk_tab(ptab);
		// Both copies bad: defaults are loaded
		ccr_store_model_i.prot_mem[7] ^= 16'h0001;
		ptab[7] ^= 16'h0001;
		req(2);
		req(0);
		check({fault, rmsg, dmsg}, 16'h0005);
		chk_tab(dtab);
		chk_prot(ptab);
		req(3);
		k = 0;
		repeat (4 * FLASH) begin
			last = cal;
			@(posedge clock_i) #2;
			if (cal !== last) k++;
		end
		check({dshow, k >= 3}, 16'h0003);
		work = dtab;
		wr(7'h62, 16'h1234);
		req(0);
		check({fault, dmsg}, 16'h0000);
		chk_tab(work);
		slow = 1'b0;
		fail_en = 1'b1;
		req(1);
		check(fmsg, 16'h0001);
		print_verdict();
	end
endmodule // tb_cal_constant_checksum_restore
